// >>> pkg/dsps_map.svh
// offsets, field positions, reset values and timing counts of the sweep link
`ifndef DSPS_MAP_SVH
`define DSPS_MAP_SVH

// serial word layout
`define DSPS_WORD_W        16
`define DSPS_ADDR_W        4
`define DSPS_DATA_W        12
`define DSPS_BITCNT_LAST   5'h0F

// device register addresses carried in the word
`define DSPS_A_CTRL        4'h0
`define DSPS_A_START_LO    4'h1
`define DSPS_A_START_HI    4'h2
`define DSPS_A_DELTA_LO    4'h3
`define DSPS_A_DELTA_HI    4'h4
`define DSPS_A_NINCR       4'h5
`define DSPS_A_TINT        4'h6

// device control word fields
`define DSPS_C_TRIANGLE    0
`define DSPS_C_EXT_INCR    1
`define DSPS_C_STATUS_SEL  2
`define DSPS_C_STATUS_EN   3
`define DSPS_C_SIGN_EN     4
`define DSPS_C_BURST       5
`define DSPS_CTRL_RST      12'h000

// frequency and dac widths
`define DSPS_FREQ_W        24
`define DSPS_DAC_W         10
`define DSPS_DAC_MID       10'h200

// host register byte offsets on apb
`define DSPS_R_TXDATA      12'h000
`define DSPS_R_STATUS      12'h004
`define DSPS_R_PINS        12'h008
`define DSPS_R_OBSERVE     12'h00C
`define DSPS_PIN_CTRL      0
`define DSPS_PIN_ABORT     1
`define DSPS_PIN_STANDBY   2

// serial clock half period
`define DSPS_CLK_NS        5
`define DSPS_SCLK_HALF_NS  40
`define DSPS_SCLK_HALF_CYC ((`DSPS_SCLK_HALF_NS + `DSPS_CLK_NS - 1) / `DSPS_CLK_NS)

`endif

// >>> pkg/dsps_pkg.sv
// types shared by both ends of the sweep link
package dsps_pkg;
  typedef enum logic [0:0] {DSPS_DEV_IDLE, DSPS_DEV_RUN}                 dsps_dev_state_e;
  typedef enum logic [2:0] {DSPS_TX_IDLE, DSPS_TX_LEAD, DSPS_TX_LOW,
                            DSPS_TX_HIGH, DSPS_TX_TRAIL}                  dsps_tx_state_e;
endpackage : dsps_pkg

// >>> pkg/dsps_if.sv
// pin bundle between the host controller and the sweep device
interface dsps_if;
  logic word_frame_n;
  logic sclk;
  logic serial_data_in;
  logic sweep_ctrl;
  logic sweep_abort;
  logic standby;
  logic sweep_status_out;
  logic sign_bit_out;

  modport host (output word_frame_n, output sclk, output serial_data_in,
                output sweep_ctrl, output sweep_abort, output standby,
                input sweep_status_out, input sign_bit_out);
  modport device (input word_frame_n, input sclk, input serial_data_in,
                  input sweep_ctrl, input sweep_abort, input standby,
                  output sweep_status_out, output sign_bit_out);
endinterface : dsps_if

// >>> hdl/dsps_host.sv
// host end: apb register slave that drives the serial link and control pins
`include "dsps_map.svh"

module dsps_host #(
  parameter int HALF_CYC = `DSPS_SCLK_HALF_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  dsps_if.host             link
);

  dsps_pkg::dsps_tx_state_e state_r;
  logic [15:0] shift_r;
  logic [3:0]  bit_r;
  logic [7:0]  div_r;
  logic [2:0]  pins_r;
  logic        frame_n_r;
  logic        sclk_r;
  logic [1:0]  stat_q;
  logic [1:0]  sign_q;
  logic        stat_seen_r;
  logic        apb_wr;
  logic        apb_rd;
  logic        tx_go;
  logic        half_done;

  // apb access phase decode, zero wait states
  assign apb_wr    = i_psel & i_penable & i_pwrite;
  assign apb_rd    = i_psel & i_penable & ~i_pwrite;
  assign tx_go     = apb_wr && i_paddr == `DSPS_R_TXDATA && state_r == dsps_pkg::DSPS_TX_IDLE;
  assign half_done = div_r == 8'(HALF_CYC - 1);
  assign o_pready  = 1'b1;

  // busy write to txdata or unmapped address gives an error
  always_comb begin
    o_pslverr = 1'b0;
    if (i_psel & i_penable) begin
      case (i_paddr)
        `DSPS_R_TXDATA:  o_pslverr = i_pwrite & (state_r != dsps_pkg::DSPS_TX_IDLE);
        `DSPS_R_STATUS:  o_pslverr = 1'b0;
        `DSPS_R_PINS:    o_pslverr = 1'b0;
        `DSPS_R_OBSERVE: o_pslverr = 1'b0;
        default:         o_pslverr = 1'b1;
      endcase
    end
  end

  // read data register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel & ~i_penable & ~i_pwrite) begin
      case (i_paddr)
        `DSPS_R_STATUS:  o_prdata <= {31'h0000_0000, state_r != dsps_pkg::DSPS_TX_IDLE};
        `DSPS_R_PINS:    o_prdata <= {29'h0000_0000, pins_r};
        `DSPS_R_OBSERVE: o_prdata <= {29'h0000_0000, sign_q[1], stat_q[1], stat_seen_r};
        default:         o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // control pin levels set by software
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pins_r <= 3'h0;
    end else if (apb_wr && i_paddr == `DSPS_R_PINS) begin
      pins_r <= i_pwdata[2:0];
    end
  end

  // sync device outputs, sticky status seen, set wins over write one clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_q      <= 2'h0;
      sign_q      <= 2'h0;
      stat_seen_r <= 1'b0;
    end else begin
      stat_q <= {stat_q[0], link.sweep_status_out};
      sign_q <= {sign_q[0], link.sign_bit_out};
      if (stat_q[1]) begin
        stat_seen_r <= 1'b1;
      end else if (apb_rd == 1'b0 && apb_wr && i_paddr == `DSPS_R_OBSERVE && i_pwdata[0]) begin
        stat_seen_r <= 1'b0;
      end
    end
  end

  // serial word engine: frame low, data changes on rising sclk, msb first
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r   <= dsps_pkg::DSPS_TX_IDLE;
      shift_r   <= 16'h0000;
      bit_r     <= 4'h0;
      div_r     <= 8'h00;
      frame_n_r <= 1'b1;
      sclk_r    <= 1'b1;
    end else begin
      div_r <= half_done ? 8'h00 : div_r + 8'h01;
      case (state_r)
        dsps_pkg::DSPS_TX_IDLE: begin
          div_r <= 8'h00;
          if (tx_go) begin
            shift_r   <= i_pwdata[15:0]; // R01
            bit_r     <= 4'h0;
            frame_n_r <= 1'b0;           // R03
            state_r   <= dsps_pkg::DSPS_TX_LEAD;
          end
        end
        dsps_pkg::DSPS_TX_LEAD, dsps_pkg::DSPS_TX_HIGH: begin
          if (half_done) begin
            sclk_r  <= 1'b0;
            state_r <= dsps_pkg::DSPS_TX_LOW;
          end
        end
        dsps_pkg::DSPS_TX_LOW: begin
          if (half_done) begin
            sclk_r <= 1'b1;
            bit_r  <= bit_r + 4'h1;
            if (bit_r == 4'hF) begin
              state_r <= dsps_pkg::DSPS_TX_TRAIL;
            end else begin
              shift_r <= {shift_r[14:0], 1'b0}; // R01
              state_r <= dsps_pkg::DSPS_TX_HIGH;
            end
          end
        end
        dsps_pkg::DSPS_TX_TRAIL: begin
          if (half_done) begin
            frame_n_r <= 1'b1;
            state_r   <= dsps_pkg::DSPS_TX_IDLE;
          end
        end
        default: state_r <= dsps_pkg::DSPS_TX_IDLE;
      endcase
    end
  end

  assign link.word_frame_n   = frame_n_r;
  assign link.sclk           = sclk_r;
  assign link.serial_data_in = shift_r[15];
  assign link.sweep_ctrl     = pins_r[`DSPS_PIN_CTRL];    // R06
  assign link.sweep_abort    = pins_r[`DSPS_PIN_ABORT];
  assign link.standby        = pins_r[`DSPS_PIN_STANDBY]; // R14

endmodule : dsps_host

// >>> hdl/dsps_device.sv
// device end: serial word loader, sweep engine and status outputs
`include "dsps_map.svh"

// Operation
// R01 - 16-bit word, address first, data msb first
// R02 - sample data on each falling serial clock
// R03 - frame low starts loading a fresh word
// R04 - control rise initialises and starts sweep
// R05 - auto mode: one pulse runs whole sweep
// R06 - external mode: one step per pulse
// R07 - abort rise resets sweep state machines
// R08 - after abort dac sits at midscale
// R09 - status shows end of sweep or increments
// R10 - status output only when enabled
// R11 - sign output is inverted dac msb
// R12 - sign output only when enabled
// R13 - standby high stops the core clock
// R14 - host resets device before standby; the host here only drives standby from pins bit 2, with no reset before it
// R15 - output frequency is fraction of clock
// R16 - external step interval follows control rises
// R17 - burst: output while high, midscale while low
// R18 - sweep repeats, saw or triangle form
// R19 - control and abort pass two-stage synchroniser
// R20 - partial word discarded on early frame end
module dsps_device #(
  parameter int FREQ_W = `DSPS_FREQ_W,
  parameter int DAC_W  = `DSPS_DAC_W
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  dsps_if.device                 link,
  output logic [DAC_W-1:0]       o_dac_data,
  output logic [FREQ_W-1:0]      o_freq_word,
  output logic                   o_sweeping
);

  localparam logic [DAC_W-1:0] MID = DAC_W'(`DSPS_DAC_MID);

  dsps_pkg::dsps_dev_state_e state_r;
  logic [1:0]        frm_q;
  logic [1:0]        sck_q;
  logic [1:0]        sdi_q;
  logic [1:0]        ctl_q;
  logic [1:0]        abt_q;
  logic [1:0]        stb_q;
  logic              sck_d;
  logic              ctl_d;
  logic              abt_d;
  logic [4:0]        bit_r;
  logic [15:0]       shift_r;
  logic              wr_stb_r;
  logic [15:0]       wr_word_r;
  logic [11:0]       ctrl_r;
  logic [23:0]       start_r;
  logic [23:0]       delta_r;
  logic [11:0]       nincr_r;
  logic [11:0]       tint_r;
  logic [11:0]       cnt_r;
  logic [11:0]       tcnt_r;
  logic              up_r;
  logic [FREQ_W-1:0] freq_r;
  logic [FREQ_W-1:0] phase_r;
  logic              eos_r;
  logic              incr_r;
  logic              status_r;
  logic              sign_r;
  logic              sck_fall;
  logic              ctl_rise;
  logic              abt_rise;
  logic              core_on;
  logic              step;
  logic              burst_low;

  // two-stage synchronisers, edges taken from the second stage only
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      frm_q <= 2'h3;
      sck_q <= 2'h3;
      sdi_q <= 2'h0;
      ctl_q <= 2'h0; // R19
      abt_q <= 2'h0; // R19
      stb_q <= 2'h0;
      sck_d <= 1'b1;
      ctl_d <= 1'b0;
      abt_d <= 1'b0;
    end else begin
      frm_q <= {frm_q[0], link.word_frame_n};
      sck_q <= {sck_q[0], link.sclk};
      sdi_q <= {sdi_q[0], link.serial_data_in};
      ctl_q <= {ctl_q[0], link.sweep_ctrl};  // R19
      abt_q <= {abt_q[0], link.sweep_abort}; // R19
      stb_q <= {stb_q[0], link.standby};
      sck_d <= sck_q[1];
      ctl_d <= ctl_q[1];
      abt_d <= abt_q[1];
    end
  end

  // edge events and core clock gate model
  assign sck_fall  = sck_d & ~sck_q[1];
  assign ctl_rise  = ctl_q[1] & ~ctl_d;
  assign abt_rise  = abt_q[1] & ~abt_d;
  assign core_on   = ~stb_q[1];                             // R13
  assign burst_low = ctrl_r[`DSPS_C_BURST] & ~ctl_q[1];

  // serial loader, stays active in standby
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bit_r     <= 5'h00;
      shift_r   <= 16'h0000;
      wr_stb_r  <= 1'b0;
      wr_word_r <= 16'h0000;
    end else begin
      wr_stb_r <= 1'b0;
      if (frm_q[1]) begin
        bit_r <= 5'h00;                                      // R03 R20
      end else if (sck_fall) begin
        shift_r <= {shift_r[14:0], sdi_q[1]};                // R02
        if (bit_r == `DSPS_BITCNT_LAST) begin
          bit_r     <= 5'h00;
          wr_stb_r  <= 1'b1;
          wr_word_r <= {shift_r[14:0], sdi_q[1]};            // R01
        end else begin
          bit_r <= bit_r + 5'h01;
        end
      end
    end
  end

  // register file written from complete words
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_r  <= `DSPS_CTRL_RST;
      start_r <= 24'h00_0000;
      delta_r <= 24'h00_0000;
      nincr_r <= 12'h000;
      tint_r  <= 12'h000;
    end else if (wr_stb_r) begin
      case (wr_word_r[15:12])                                // R01
        `DSPS_A_CTRL:     ctrl_r          <= wr_word_r[11:0];
        `DSPS_A_START_LO: start_r[11:0]   <= wr_word_r[11:0];
        `DSPS_A_START_HI: start_r[23:12]  <= wr_word_r[11:0];
        `DSPS_A_DELTA_LO: delta_r[11:0]   <= wr_word_r[11:0];
        `DSPS_A_DELTA_HI: delta_r[23:12]  <= wr_word_r[11:0];
        `DSPS_A_NINCR:    nincr_r         <= wr_word_r[11:0];
        `DSPS_A_TINT:     tint_r          <= wr_word_r[11:0];
        default:          ctrl_r          <= ctrl_r;
      endcase
    end
  end

  // step source: interval timer in auto mode, control rises in external mode
  assign step = ctrl_r[`DSPS_C_EXT_INCR] ? ctl_rise : (tcnt_r == tint_r); // R05 R06 R16

  // sweep state machine
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= dsps_pkg::DSPS_DEV_IDLE;
      freq_r  <= '0;
      cnt_r   <= 12'h000;
      tcnt_r  <= 12'h000;
      up_r    <= 1'b1;
      eos_r   <= 1'b0;
      incr_r  <= 1'b0;
    end else if (core_on) begin
      eos_r  <= 1'b0;
      incr_r <= 1'b0;
      if (abt_rise) begin
        state_r <= dsps_pkg::DSPS_DEV_IDLE;                  // R07
      end else begin
        case (state_r)
          dsps_pkg::DSPS_DEV_IDLE: begin
            if (ctl_rise) begin
              freq_r  <= start_r;                            // R04
              cnt_r   <= 12'h000;
              tcnt_r  <= 12'h000;
              up_r    <= 1'b1;
              state_r <= dsps_pkg::DSPS_DEV_RUN;
            end
          end
          dsps_pkg::DSPS_DEV_RUN: begin
            tcnt_r <= (step || tcnt_r == tint_r) ? 12'h000 : tcnt_r + 12'h001;
            if (step) begin
              incr_r <= 1'b1;
              if (up_r && cnt_r != nincr_r) begin
                freq_r <= freq_r + delta_r;
                cnt_r  <= cnt_r + 12'h001;
              end else if (up_r && ctrl_r[`DSPS_C_TRIANGLE] && cnt_r != 12'h000) begin
                up_r   <= 1'b0;                              // R18
                freq_r <= freq_r - delta_r;
                cnt_r  <= cnt_r - 12'h001;
              end else if (up_r) begin
                freq_r <= start_r;                           // R18
                cnt_r  <= 12'h000;
                eos_r  <= 1'b1;
              end else if (cnt_r != 12'h000) begin
                freq_r <= freq_r - delta_r;
                cnt_r  <= cnt_r - 12'h001;
              end else begin
                up_r   <= 1'b1;                              // R18
                freq_r <= freq_r + delta_r;
                cnt_r  <= cnt_r + 12'h001;
                eos_r  <= 1'b1;
              end
            end
          end
          default: state_r <= dsps_pkg::DSPS_DEV_IDLE;
        endcase
      end
    end
  end

  // phase accumulator, output rate is freq over two to the width
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phase_r <= '0;
    end else if (core_on) begin
      if (state_r != dsps_pkg::DSPS_DEV_RUN || abt_rise || burst_low) begin
        phase_r <= '0;
      end else begin
        phase_r <= phase_r + freq_r;                         // R15
      end
    end
  end

  // dac word, midscale when idle or burst gated low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_dac_data <= MID;
    end else if (core_on) begin
      if (state_r != dsps_pkg::DSPS_DEV_RUN || abt_rise) begin
        o_dac_data <= MID;                                   // R08
      end else if (burst_low) begin
        o_dac_data <= MID;                                   // R17
      end else begin
        o_dac_data <= phase_r[FREQ_W-1 -: DAC_W];
      end
    end
  end

  // status and sign pins
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_r <= 1'b0;
      sign_r   <= 1'b0;
    end else if (core_on) begin
      status_r <= ctrl_r[`DSPS_C_STATUS_EN] &
                  (ctrl_r[`DSPS_C_STATUS_SEL] ? eos_r : incr_r); // R09 R10
      sign_r   <= ctrl_r[`DSPS_C_SIGN_EN] & ~o_dac_data[DAC_W-1]; // R11 R12
    end
  end

  // user-side observation
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_freq_word <= '0;
      o_sweeping  <= 1'b0;
    end else begin
      o_freq_word <= freq_r;
      o_sweeping  <= state_r == dsps_pkg::DSPS_DEV_RUN;
    end
  end

  assign link.sweep_status_out = status_r;
  assign link.sign_bit_out     = sign_r;

endmodule : dsps_device

// >>> verification/dsps_chk.sv
// concurrent checks on the pins between host and sweep device
module dsps_chk #(
  parameter int HALF_CYC = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic word_frame_n,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic sweep_ctrl,
  input wire logic sweep_abort,
  input wire logic standby,
  input wire logic sweep_status_out,
  input wire logic sign_bit_out
);
  logic       sclk_q_r;
  logic [4:0] fall_cnt_r;
  logic [7:0] low_cnt_r;
  logic [4:0] stby_r;
  logic       quiet;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // serial clock history and standby history
  always_ff @(posedge i_clk) sclk_q_r <= i_rst ? 1'b1 : sclk;
  always_ff @(posedge i_clk) stby_r <= i_rst ? 5'h00 : {stby_r[3:0], standby};
  assign quiet = !standby && (stby_r == 5'h00);

  // falling serial clock edges inside one frame
  always_ff @(posedge i_clk) begin
    if (i_rst || word_frame_n) fall_cnt_r <= 5'h00;
    else if (sclk_q_r && !sclk) fall_cnt_r <= fall_cnt_r + 5'h01;
  end

  // length of the current serial clock low phase
  always_ff @(posedge i_clk) begin
    if (i_rst || sclk) low_cnt_r <= 8'h00;
    else low_cnt_r <= low_cnt_r + 8'h01;
  end

  // lead phase length equals the default half period
  sequence lead_s;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence quiet_s;
    (!sweep_status_out && !sign_bit_out) [*8];
  endsequence

  frame_lead_a: assert property ($fell(word_frame_n) |-> lead_s)
    else $error("serial clock lead after frame start wrong");
  word_bits_a: assert property ($rose(word_frame_n) |-> fall_cnt_r == 5'h10)
    else $error("frame did not carry sixteen bits");
  data_hold_a: assert property (!word_frame_n && !sclk |-> $stable(serial_data_in))
    else $error("data moved while serial clock low");
  low_phase_a: assert property ($rose(sclk) |-> low_cnt_r == 8'(HALF_CYC))
    else $error("serial clock low phase length wrong");
  idle_clock_a: assert property (word_frame_n |-> sclk)
    else $error("serial clock low outside a frame");
  frame_trail_a: assert property ($rose(word_frame_n) |-> $past(sclk, 8) && !$past(sclk, 9))
    else $error("frame end trail wrong");
  status_pulse_a: assert property (sweep_status_out && quiet |=> !sweep_status_out)
    else $error("status output longer than one clock");
  abort_quiet_a: assert property ($rose(sweep_abort) && quiet |-> ##6 quiet_s)
    else $error("outputs active after abort");
  standby_hold_a: assert property (standby [*6] |-> $stable(sign_bit_out)
                                   && $stable(sweep_status_out))
    else $error("outputs moved in standby");
endmodule : dsps_chk

// >>> verification/dds_sweep_pin_control_test.sv
// top bench: apb host end and sweep device joined over the pin bundle
`include "dsps_map.svh"
`define DSPS_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch at %0t got %0h exp %0h", $time, (g), (e)); end end

module dds_sweep_pin_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 8;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, rerr, swp, sclk_q, m;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [9:0]  dac, d;
  logic [23:0] freq, freq2, f;
  logic [15:0] cap;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [15:0] prog [7] = '{{`DSPS_A_START_LO, 12'h000}, {`DSPS_A_START_HI, 12'h080},
    {`DSPS_A_DELTA_LO, 12'h000}, {`DSPS_A_DELTA_HI, 12'h001}, {`DSPS_A_NINCR, 12'h002},
    {`DSPS_A_TINT, 12'h028}, {`DSPS_A_CTRL, 12'h01C}};
  dsps_if link ();
  dsps_if link2 ();

  dsps_host #(.HALF_CYC(HALF)) dsps_host_i (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(link));
  dsps_device dsps_device_i (.i_clk(i_clk), .i_rst(i_rst), .link(link), .o_dac_data(dac),
    .o_freq_word(freq), .o_sweeping(swp));
  dsps_device dsps_device_b_i (.i_clk(i_clk), .i_rst(i_rst), .link(link2), .o_dac_data(),
    .o_freq_word(freq2), .o_sweeping());
  dsps_chk #(.HALF_CYC(HALF)) dsps_chk_i (.i_clk(i_clk), .i_rst(i_rst),
    .word_frame_n(link.word_frame_n), .sclk(link.sclk), .serial_data_in(link.serial_data_in),
    .sweep_ctrl(link.sweep_ctrl), .sweep_abort(link.sweep_abort), .standby(link.standby),
    .sweep_status_out(link.sweep_status_out), .sign_bit_out(link.sign_bit_out));

  // clock
  always #2.5 i_clk = ~i_clk;

  // shift in wire bits at each seen serial clock fall
  always @(posedge i_clk) begin
    sclk_q <= link.sclk;
    if (!link.word_frame_n && sclk_q && !link.sclk) cap <= {cap[14:0], link.serial_data_in};
  end

  // hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      end_of_test();
    end
  end

  task end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  // one apb transfer, waits for pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task send_wait(input logic [15:0] w);
    do apb(1'b0, `DSPS_R_STATUS, 32'h0000_0000); while (rdata[0] === 1'b1);
    `DSPS_CHK(cap, w)
  endtask : send_wait

  task send(input logic [15:0] w);
    apb(1'b1, `DSPS_R_TXDATA, {16'h0000, w});
    send_wait(w);
  endtask : send

  task pins(input logic [2:0] v);
    apb(1'b1, `DSPS_R_PINS, {29'h0000_0000, v});
  endtask : pins

  task obs(input logic e);
    repeat (4) @(posedge i_clk); // status pulse needs time to reach the sticky bit
    apb(1'b0, `DSPS_R_OBSERVE, 32'h0000_0000);
    `DSPS_CHK(rdata[0], e)
  endtask : obs

  task waitf(input logic [23:0] e);
    int n;
    n = 0;
    while (freq !== e && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    `DSPS_CHK(freq, e)
  endtask : waitf

  // bench-driven host on the second bundle, may cut a frame short
  task bb(input logic [15:0] w, input int nb);
    @(posedge i_clk);
    link2.word_frame_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      link2.serial_data_in <= w[15-i];
      repeat (4) @(posedge i_clk);
      link2.sclk <= 1'b0;
      repeat (4) @(posedge i_clk);
      link2.sclk <= 1'b1;
    end
    repeat (4) @(posedge i_clk);
    link2.word_frame_n <= 1'b1;
    link2.serial_data_in <= ~w[16-nb];
    repeat (4) @(posedge i_clk);
  endtask : bb

  // main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    link2.word_frame_n = 1'b1;
    link2.sclk = 1'b1;
    link2.serial_data_in = 1'b0;
    link2.sweep_ctrl = 1'b0;
    link2.sweep_abort = 1'b0;
    link2.standby = 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    `DSPS_CHK(dac, `DSPS_DAC_MID)
    `DSPS_CHK(link.sign_bit_out, 1'b0)
    apb(1'b0, 12'h010, 32'h0000_0000);
    `DSPS_CHK({rerr, rdata}, 33'h1_0000_0000)
    apb(1'b1, `DSPS_R_TXDATA, 32'h0000_0000);
    apb(1'b1, `DSPS_R_TXDATA, 32'h0000_1FFF);
    `DSPS_CHK(rerr, 1'b1)
    send_wait(16'h0000);
    foreach (prog[i]) send(prog[i]);
    pins(3'h1);
    pins(3'h0);
    waitf(24'h080000);
    waitf(24'h081000);
    waitf(24'h082000);
    obs(1'b0);
    waitf(24'h080000);
    obs(1'b1);
    for (int i = 0; i < 40; i++) begin
      m = dac[9];
      @(posedge i_clk);
      `DSPS_CHK(link.sign_bit_out, ~m)
    end
    pins(3'h4);
    repeat (8) @(posedge i_clk);
    `DSPS_CHK(link.standby, 1'b1)
    f = freq;
    d = dac;
    repeat (60) @(posedge i_clk);
    `DSPS_CHK({freq, dac}, {f, d})
    pins(3'h0);
    repeat (8) @(posedge i_clk);
    `DSPS_CHK(swp, 1'b1)
    pins(3'h2);
    repeat (8) @(posedge i_clk);
    `DSPS_CHK({swp, dac}, {1'b0, `DSPS_DAC_MID})
    pins(3'h0);
    send({`DSPS_A_CTRL, 12'h00A});
    pins(3'h1);
    pins(3'h0);
    waitf(24'h080000);
    repeat (60) @(posedge i_clk);
    `DSPS_CHK(freq, 24'h080000)
    apb(1'b1, `DSPS_R_OBSERVE, 32'h0000_0001);
    pins(3'h1);
    pins(3'h0);
    waitf(24'h081000);
    obs(1'b1);
    `DSPS_CHK(link.sign_bit_out, 1'b0)
    send({`DSPS_A_CTRL, 12'h02A});
    repeat (8) @(posedge i_clk);
    `DSPS_CHK(dac, `DSPS_DAC_MID)
    pins(3'h1);
    repeat (40) @(posedge i_clk);
    `DSPS_CHK(dac !== `DSPS_DAC_MID, 1'b1)
    bb({`DSPS_A_START_HI, 12'h000}, 16);
    bb({`DSPS_A_START_LO, 12'h123}, 16);
    bb({`DSPS_A_START_LO, 12'hFFF}, 12);
    bb({`DSPS_A_START_LO, 12'h456}, 16);
    link2.sweep_ctrl <= 1'b1;
    repeat (8) @(posedge i_clk);
    `DSPS_CHK(freq2, 24'h000456)
    `DSPS_CHK(link2.sweep_status_out, 1'b0)
    end_of_test();
  end
endmodule : dds_sweep_pin_control_test
